//--- rtl/loop_status_cfg.svh
// bit positions, offsets and reset values of the loop status words
// assumes inclusion by the status block and the testbench only
`ifndef LOOP_STATUS_CFG_SVH
`define LOOP_STATUS_CFG_SVH
`define LOOP_ONE_STATUS_OFS   4'h8
`define LOOP_TWO_STATUS_OFS   4'h9
`define BIT_FIRST_ALARM       1
`define BIT_SECOND_ALARM      0
`define BIT_SAVE_DONE         15
`define BIT_SENSOR_ERR        14
`define BIT_CUR_OVERFLOW      13
`define BIT_FATAL_ERR         12
`define BIT_STANDBY           11
`define BIT_TUNED_PENDING     10
`define BIT_SETTING_ERR       9
`define BIT_SAVE_REQUEST      14
`define CUR_OVERFLOW_LIMIT    16'h0226
`define SAVE_COPY_CYCLES      8'h10
`define STATUS_WORD_RESET     16'h0000
`define STATUS_TWO_RESET      16'h0800
`endif

//--- rtl/loop_status_pkg.sv
// types of the loop status block
// assumes the cfg header for numeric constants
package loop_status_pkg;
   typedef struct packed {
      logic        sensor_absent;
      logic        sensor_broken;
      logic        temp_out_of_range;
      logic        cjc_fault;
      logic        host_wdt_error;
      logic        tuned_update;
      logic        tuned_delivered;
      logic        setting_invalid;
   } cond_t;
   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] alarm1_lo;
      logic [15:0] alarm1_hi;
      logic [15:0] alarm2_lo;
      logic [15:0] alarm2_hi;
      logic [15:0] heater_cur;
   } meas_t;
   typedef enum logic [2:0] {
      SAVE_IDLE = 3'b001,
      SAVE_COPY = 3'b010,
      SAVE_DONE = 3'b100
   } save_state_t;
endpackage

//--- rtl/sync_bit.sv
// two-flop synchroniser for one asynchronous level
// assumes the destination runs on clk_sys
`timescale 1ns/1ps
module sync_bit (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // level in and out
   input  wire logic din,
   output logic      dout
);
   logic meta_ff;
   // first stage read only by the second
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         dout    <= 1'b0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule // sync_bit

//--- rtl/loop_status_flag_word.sv
// loop one alarm bits and loop two status word reported to the host
// assumes io_refresh and save_request come from host logic on clk_sys;
// condition inputs come from pins and are synchronised here
// What this block does
// - alarm bits set while temperature inside their range, clear outside.
// - save-completed bit set once the RAM-to-EEPROM copy finishes.
// - host sets save request; device starts the copy on seeing it.
// - save-completed clears as soon as save request becomes set.
// - save-completed reads cleared right after power-up.
// - sensor error on absent sensor, broken wire or out-of-range input.
// - current overflow set while heater current exceeds the limit.
// - fatal error on cold-junction fault or host watchdog error.
// - standby set while waiting for first refresh after start or restart.
// - tuned-constants bit set when autotuning updates PID constants.
// - while tuned bit set, host constants count as undelivered.
// - setting error set when any host setting is invalid.
`timescale 1ns/1ps
`include "loop_status_cfg.svh"
module loop_status_flag_word (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // host refresh side
   input  wire logic                   io_refresh,
   input  wire logic                   save_request,
   input  wire logic                   module_restart,
   // pin conditions and measurements
   input  wire loop_status_pkg::cond_t cond_in,
   input  wire loop_status_pkg::meas_t meas,
   // eeprom copy engine
   output logic                        copy_start,
   input  wire logic                   copy_done,
   // status words
   output logic [15:0]                 loop_one_status_word,
   output logic [15:0]                 loop_two_status_word
);
   import loop_status_pkg::*;

   cond_t       cond_s;
   save_state_t save_ff;
   save_state_t nxt_save;
   logic        save_req_d_ff;
   logic        standby_ff;
   logic        tuned_ff;
   logic        save_done_ff;
   logic        nxt_save_done;
   logic [15:0] nxt_one;
   logic [15:0] nxt_two;

   // pin conditions cross into clk_sys per bit
   genvar gi;
   generate
      for (gi = 0; gi < $bits(cond_t); gi = gi + 1) begin : g_sync
         sync_bit u_sync (
            .clk_sys (clk_sys),
            .rst     (rst),
            .din     (cond_in[gi]),
            .dout    (cond_s[gi])
         );
      end
   endgenerate

   // decode of the live conditions
   wire save_rise  = save_request & ~save_req_d_ff;
   wire alarm1_in  = (meas.temp >= meas.alarm1_lo) && (meas.temp <= meas.alarm1_hi);
   wire alarm2_in  = (meas.temp >= meas.alarm2_lo) && (meas.temp <= meas.alarm2_hi);
   wire sensor_err = cond_s.sensor_absent | cond_s.sensor_broken | cond_s.temp_out_of_range;
   wire cur_ovf    = meas.heater_cur > `CUR_OVERFLOW_LIMIT;
   wire fatal_err  = cond_s.cjc_fault | cond_s.host_wdt_error;
   wire set_err    = cond_s.setting_invalid;
   // live standby, so a restart shows before the next refresh
   wire standby_live = standby_ff | module_restart;

   // save sequencer next state
   always_comb begin
      nxt_save = save_ff;
      case (save_ff)
         SAVE_IDLE: if (save_rise) nxt_save = SAVE_COPY;
         // a fresh request beats a done in the same cycle; the restarted copy brings its own
         SAVE_COPY: if (copy_done && !save_rise) nxt_save = SAVE_DONE;
         SAVE_DONE: if (save_rise) nxt_save = SAVE_COPY;
         default:   nxt_save = SAVE_IDLE;
      endcase
   end

   // completion flag: new request wins so each save starts deasserted
   // clear on request
   assign nxt_save_done = save_rise ? 1'b0 :
                          (save_ff == SAVE_COPY && copy_done) ? 1'b1 : save_done_ff;

   // words assembled from live conditions, latched on refresh
   always_comb begin
      nxt_one = `STATUS_WORD_RESET;
      nxt_one[`BIT_FIRST_ALARM]  = alarm1_in;
      nxt_one[`BIT_SECOND_ALARM] = alarm2_in;
      nxt_two = `STATUS_WORD_RESET;
      nxt_two[`BIT_SAVE_DONE]     = nxt_save_done;
      nxt_two[`BIT_SENSOR_ERR]    = sensor_err;
      nxt_two[`BIT_CUR_OVERFLOW]  = cur_ovf;
      nxt_two[`BIT_FATAL_ERR]     = fatal_err;
      nxt_two[`BIT_STANDBY]       = standby_ff & ~io_refresh;
      nxt_two[`BIT_TUNED_PENDING] = tuned_ff;
      nxt_two[`BIT_SETTING_ERR]   = set_err;
   end

   // save sequencer and completion
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         save_ff       <= SAVE_IDLE;
         save_req_d_ff <= 1'b0;
         save_done_ff  <= 1'b0;
         copy_start    <= 1'b0;
      end else begin
         save_ff       <= nxt_save;
         save_req_d_ff <= save_request;
         save_done_ff  <= nxt_save_done;
         copy_start    <= save_rise;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         standby_ff <= 1'b1;
      end else if (module_restart) begin
         standby_ff <= 1'b1;
      end else if (io_refresh) begin
         standby_ff <= 1'b0;
      end
   end

   // delivery clears pending; an update in the same cycle wins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tuned_ff <= 1'b0;
      end else if (cond_s.tuned_update) begin
         tuned_ff <= 1'b1;
      end else if (cond_s.tuned_delivered) begin
         tuned_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         loop_one_status_word <= `STATUS_WORD_RESET;
         loop_two_status_word <= `STATUS_TWO_RESET;
      end else if (io_refresh) begin
         loop_one_status_word <= nxt_one;
         loop_two_status_word <= nxt_two;
      end else begin
         loop_two_status_word[`BIT_SAVE_DONE] <= nxt_save_done;
         loop_two_status_word[`BIT_STANDBY]   <= standby_live;
      end
   end

   // checks
   AST_ALARM_WINDOW: assert property (@(posedge clk_sys) disable iff (rst)
      io_refresh |=> loop_one_status_word[`BIT_FIRST_ALARM] == $past(alarm1_in))
      else $error("first alarm bit wrong after refresh");
   AST_DONE_SET: assert property (@(posedge clk_sys) disable iff (rst)
      (save_ff == SAVE_COPY && copy_done && !save_rise) |=> loop_two_status_word[15])
      else $error("save done not set");
   AST_COPY_START: assert property (@(posedge clk_sys) disable iff (rst)
      (save_request && !save_req_d_ff) |=> copy_start && save_ff == SAVE_COPY)
      else $error("copy not started on request");
   AST_DONE_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      (save_request && !save_req_d_ff) |=> !loop_two_status_word[15])
      else $error("save done not cleared on request");
   AST_SENSOR: assert property (@(posedge clk_sys) disable iff (rst)
      (io_refresh && sensor_err) |=> loop_two_status_word[`BIT_SENSOR_ERR])
      else $error("sensor error missing");
   AST_OVF: assert property (@(posedge clk_sys) disable iff (rst)
      io_refresh |=> loop_two_status_word[`BIT_CUR_OVERFLOW] == $past(cur_ovf))
      else $error("overflow bit wrong");
   AST_FATAL: assert property (@(posedge clk_sys) disable iff (rst)
      (io_refresh && fatal_err) |=> loop_two_status_word[`BIT_FATAL_ERR])
      else $error("fatal bit missing");
   AST_STANDBY: assert property (@(posedge clk_sys) disable iff (rst)
      (io_refresh && !module_restart) |=> !standby_ff ##1 !standby_ff [*1])
      else $error("standby not cleared by refresh");
   AST_TUNED: assert property (@(posedge clk_sys) disable iff (rst)
      cond_s.tuned_update |=> tuned_ff)
      else $error("tuned pending not set");
   AST_SETERR: assert property (@(posedge clk_sys) disable iff (rst)
      io_refresh |=> loop_two_status_word[`BIT_SETTING_ERR] == $past(set_err))
      else $error("setting error bit wrong");
   COV_SAVE: cover property (@(posedge clk_sys) disable iff (rst) save_rise ##[1:50] copy_done);
   COV_STANDBY: cover property (@(posedge clk_sys) disable iff (rst) standby_ff ##1 !standby_ff);
   COV_ALARM: cover property (@(posedge clk_sys) disable iff (rst) io_refresh && alarm1_in && alarm2_in);
   COV_RESTART: cover property (@(posedge clk_sys) disable iff (rst) module_restart ##[1:20] io_refresh);
   COV_OVERFLOW: cover property (@(posedge clk_sys) disable iff (rst) io_refresh && cur_ovf);

   // checks on the held words and the flag registers behind them

   AST_ALARM2_WINDOW: assert property (@(posedge clk_sys) disable iff (rst)
      io_refresh
      |=> loop_one_status_word[`BIT_SECOND_ALARM] == $past(alarm2_in))
      else $error("second alarm bit wrong after refresh");

   AST_SENSOR_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      (io_refresh && !sensor_err)
      |=> !loop_two_status_word[`BIT_SENSOR_ERR])
      else $error("sensor error bit set without a fault");

   AST_FATAL_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      (io_refresh && !fatal_err)
      |=> !loop_two_status_word[`BIT_FATAL_ERR])
      else $error("fatal bit set without a source");

   AST_DONE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      (!save_rise && !(save_ff == SAVE_COPY && copy_done))
      |=> $stable(loop_two_status_word[`BIT_SAVE_DONE]))
      else $error("save done changed without an event");

   AST_DONE_STATE: assert property (@(posedge clk_sys) disable iff (rst)
      save_ff == SAVE_DONE
      |-> loop_two_status_word[`BIT_SAVE_DONE])
      else $error("save done low in done state");

   AST_DONE_LOW_IN_COPY: assert property (@(posedge clk_sys) disable iff (rst)
      save_ff == SAVE_COPY
      |-> !loop_two_status_word[`BIT_SAVE_DONE])
      else $error("save done high while a copy runs");

   AST_COPY_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
      copy_start
      |=> !copy_start)
      else $error("copy start longer than one cycle");

   AST_COPY_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
      !save_rise
      |=> !copy_start)
      else $error("copy started without a request");

   AST_COPY_STATE: assert property (@(posedge clk_sys) disable iff (rst)
      copy_start
      |-> save_ff == SAVE_COPY)
      else $error("copy start outside the copy state");

   AST_STANDBY_SET: assert property (@(posedge clk_sys) disable iff (rst)
      module_restart
      |=> standby_ff)
      else $error("standby not set by restart");

   AST_STANDBY_WORD: assert property (@(posedge clk_sys) disable iff (rst)
      (module_restart && !io_refresh)
      |=> loop_two_status_word[`BIT_STANDBY])
      else $error("standby bit not shown after restart");

   AST_STANDBY_FALL: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(standby_ff)
      |-> $past(io_refresh))
      else $error("standby cleared without a refresh");

   AST_TUNED_WORD: assert property (@(posedge clk_sys) disable iff (rst)
      io_refresh
      |=> loop_two_status_word[`BIT_TUNED_PENDING] == $past(tuned_ff))
      else $error("tuned pending bit wrong after refresh");

   AST_TUNED_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      (cond_s.tuned_delivered && !cond_s.tuned_update)
      |=> !tuned_ff)
      else $error("tuned pending not cleared by delivery");

   AST_TUNED_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      (!cond_s.tuned_update && !cond_s.tuned_delivered)
      |=> $stable(tuned_ff))
      else $error("tuned pending changed without an event");

   AST_ONE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      !io_refresh
      |=> $stable(loop_one_status_word))
      else $error("first word changed between refreshes");

   AST_TWO_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      !io_refresh
      |=> $stable(loop_two_status_word[14:12]) && $stable(loop_two_status_word[10:0]))
      else $error("second word changed between refreshes");
endmodule // loop_status_flag_word

//--- tb/copy_engine_model.sv
// stand-in for the eeprom copy engine behind the status block
// assumes copy_start is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
module copy_engine_model #(
   parameter int COPY_CYCLES = 12
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // copy handshake
   input  wire logic slow,
   input  wire logic copy_start,
   output logic      copy_done
);
   int cnt_ff;
   // copy then done
   // a new start reloads the count, but a done already due when the count stands at 1 still follows
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_ff    <= 0;
         copy_done <= 1'b0;
      end else begin
         copy_done <= (cnt_ff == 1);
         if (copy_start) cnt_ff <= slow ? 4 * COPY_CYCLES : COPY_CYCLES;
         else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
      end
   end
endmodule // copy_engine_model

//--- tb/testbench.sv
// self-checking bench for the loop status words
// assumes the copy engine model answers each copy start
`timescale 1ns/1ps
`include "loop_status_cfg.svh"
module testbench;
   import loop_status_pkg::*;
   logic        clk_sys, rst, io_refresh, save_request, module_restart, copy_start, copy_done, slow;
   cond_t       cond_in;
   meas_t       meas, m;
   logic [15:0] loop_one_status_word, loop_two_status_word;
   logic [31:0] seed, r;
   logic        done_exp, tuned_exp;
   int          n_fail, cmp_count, cyc;

   loop_status_flag_word i_loop_status_flag_word (.clk_sys(clk_sys), .rst(rst), .io_refresh(io_refresh),
      .save_request(save_request), .module_restart(module_restart), .cond_in(cond_in), .meas(meas),
      .copy_start(copy_start), .copy_done(copy_done), .loop_one_status_word(loop_one_status_word),
      .loop_two_status_word(loop_two_status_word));
   copy_engine_model #(.COPY_CYCLES(12)) i_copy_engine_model (.clk_sys(clk_sys), .rst(rst), .slow(slow),
      .copy_start(copy_start), .copy_done(copy_done));

   // free-running clock, 25 ns period
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // hang guard, far above the expected run length
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc >= 20000) begin
         n_fail++;
         stop_test();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // inclusive range, unsigned compare
   function automatic logic [15:0] exp_one(input meas_t v);
      return {14'h0000, v.temp >= v.alarm1_lo && v.temp <= v.alarm1_hi,
              v.temp >= v.alarm2_lo && v.temp <= v.alarm2_hi};
   endfunction
   // standby reads 0 once a refresh has latched the word
   function automatic logic [15:0] exp_two(input cond_t c, input meas_t v);
      return {done_exp, c.sensor_absent | c.sensor_broken | c.temp_out_of_range, v.heater_cur > `CUR_OVERFLOW_LIMIT,
              c.cjc_fault | c.host_wdt_error, 1'b0, tuned_exp, c.setting_invalid, 9'h000};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // pins pass a two-flop synchroniser, so let them settle before the refresh
   task automatic do_refresh;
      tick(4);
      @(posedge clk_sys) io_refresh <= 1'b1;
      @(posedge clk_sys) io_refresh <= 1'b0;
      tick(1);
      chk(loop_one_status_word, exp_one(meas));
      chk(loop_two_status_word, exp_two(cond_in, meas));
   endtask
   task automatic wait_done(input logic v, input int lim);
      int k;
      k = 0;
      while (loop_two_status_word[15] !== v && k < lim) begin
         tick(1);
         k++;
      end
      chk({15'h0000, loop_two_status_word[15]}, {15'h0000, v});
   endtask
   task automatic save(input int lim);
      int k;
      k = 0;
      @(posedge clk_sys) save_request <= 1'b1;
      tick(1);
      while (copy_start !== 1'b1 && k < 3) begin
         tick(1);
         k++;
      end
      chk({15'h0000, copy_start}, 16'h0001);
      wait_done(1'b0, 0);
      done_exp = 1'b1;
      wait_done(1'b1, lim);
      @(posedge clk_sys) save_request <= 1'b0;
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // main sequence
   initial begin
      seed = 32'd71235;
      {rst, io_refresh, save_request, module_restart, slow, done_exp, tuned_exp} = 7'b1000000;
      cond_in = '0;
      meas = '0;
      tick(2);
      chk(loop_two_status_word, 16'h0800);
      chk(loop_one_status_word, 16'h0000);
      tick(3);
      @(posedge clk_sys) rst <= 1'b0;
      do_refresh();
      // random words, first two iterations pin the range and limit edges
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         r = seed;
         m.temp = r[31:16];
         m.alarm1_lo = r[31:16] - {12'h000, r[3:0]};
         m.alarm1_hi = r[31:16] + {12'h000, r[7:4]} - 16'h0008;
         m.alarm2_lo = r[31:16] + {12'h000, r[11:8]} - 16'h0004;
         m.alarm2_hi = m.alarm2_lo + {12'h000, r[15:12]};
         m.heater_cur = 16'h0220 + {12'h000, r[11:8]};
         if (i < 2) m = '{16'h0100, 16'h0100, 16'h0100, 16'h00FF, 16'h0100, 16'h0226 + i[15:0]};
         @(posedge clk_sys);
         cond_in <= cond_t'(r[7:0] & 8'hF9);
         meas <= m;
         do_refresh();
      end
      // tuned constants: update sets, delivery clears
      @(posedge clk_sys) cond_in.tuned_update <= 1'b1;
      tuned_exp = 1'b1;
      repeat (4) @(posedge clk_sys);
      cond_in.tuned_update <= 1'b0;
      do_refresh();
      @(posedge clk_sys) cond_in.tuned_delivered <= 1'b1;
      tuned_exp = 1'b0;
      do_refresh();
      @(posedge clk_sys) cond_in.tuned_delivered <= 1'b0;
      // prompt save, then a slow one whose request clears the old done
      save(40);
      slow <= 1'b1;
      tick(2);
      save(80);
      // restart: standby shows before the refresh, then the refresh clears it
      @(posedge clk_sys) module_restart <= 1'b1;
      @(posedge clk_sys) module_restart <= 1'b0;
      tick(1);
      chk({15'h0000, loop_two_status_word[`BIT_STANDBY]}, 16'h0001);
      do_refresh();
      // power-up again after a completed save: done reads cleared, standby set
      @(posedge clk_sys) rst <= 1'b1;
      done_exp = 1'b0;
      tick(2);
      chk(loop_two_status_word, `STATUS_TWO_RESET);
      @(posedge clk_sys) rst <= 1'b0;
      do_refresh();
      stop_test();
   end
endmodule // testbench
